/* File: src/mups_pin_mux.sv */
`timescale 1ns/1ps

// Summary of operation
// - Four LCD backplane outputs carry the common select waveforms.
// - Each shared pad acts as LCD pixel drive or general I/O by configuration.
// - With the EEPROM interface on, its clock goes to line 4 and its data to line 5.
// - With pulse outputs on, real-energy pulse goes to line 6 and reactive to line 7.
// - The four serial port pads each choose pixel drive or serial port function.
// - Emulator-enable high gives the three emulator pads to the emulator, low to pixel drive.
// - Clock-test and mux-sync pads choose their output or pixel drive by their own enables.
// - A test mux output shows one of sixteen internal signals picked by a four-bit select.
// - The optical receive pad is the infrared receive input or general I/O.
// - The optical transmit pad is IR LED, real pulse, reactive pulse or general I/O.
// - The chip reset input is active high and holds the backplane, all pad drives except clock-test, mux-sync and test mux, and push-button logic in reset.
// - A push-button rising edge sets the push-button flag.
// - A push-button rising edge wakes the chip from sleep or LCD-only mode.
module mups_pin_mux
  import mups_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic chipResetIn,
  output logic chipInReset,
  // LCD engine
  input wire logic [LCD_COM_N-1:0] lcdBackplaneIn,
  output logic [LCD_COM_N-1:0] lcdBackplaneOut,
  input wire logic [GIO_N-1:0] gioPixel,
  input wire logic [SPI_N-1:0] spiPixel,
  input wire logic [EMU_N-1:0] emuPixel,
  input wire logic clkTestPixel,
  input wire logic muxSyncPixel,
  // General I/O controller
  input wire logic [GIO_N-1:0] gioSelect,
  input wire logic [GIO_N-1:0] gioOut,
  input wire logic [GIO_N-1:0] gioOutEn,
  output logic [GIO_N-1:0] gioIn,
  // EEPROM and pulse sources
  input wire logic eepromEnable,
  input wire logic eepClk,
  input wire logic eepDataOut,
  input wire logic eepDataOutEn,
  output logic eepDataIn,
  input wire logic pulseEnable,
  input wire logic realEnergyPulse,
  input wire logic reactiveEnergyPulse,
  // Shared general I/O pads
  input wire logic [GIO_N-1:0] gioPadIn,
  output logic [GIO_N-1:0] gioPadOut,
  output logic [GIO_N-1:0] gioPadOe,
  // Serial port
  input wire logic [SPI_N-1:0] spiSelect,
  input wire logic spiPortDataOut,
  input wire logic spiPortDataOutEn,
  output logic spiPortClk,
  output logic spiPortSelectN,
  output logic spiPortDataIn,
  input wire logic [SPI_N-1:0] spiPadIn,
  output logic [SPI_N-1:0] spiPadOut,
  output logic [SPI_N-1:0] spiPadOe,
  // Emulator
  input wire logic emulatorEnable,
  input wire logic emulatorDataOut,
  input wire logic emulatorDataOutEn,
  input wire logic emulatorClock,
  output logic emulatorDataIn,
  output logic emulatorResetIn,
  input wire logic [EMU_N-1:0] emuPadIn,
  output logic [EMU_N-1:0] emuPadOut,
  output logic [EMU_N-1:0] emuPadOe,
  // Clock test and mux sync
  input wire logic clockTestOutEn,
  input wire logic clockTestSrc,
  output logic clockTestPad,
  input wire logic muxSyncOutEn,
  input wire logic muxSyncSrc,
  output logic muxSyncPad,
  // Test mux
  input wire logic [TMUX_W-1:0] testMuxSelect,
  input wire logic [TMUX_N-1:0] testMuxSources,
  output logic testMuxOut,
  // Optical link
  input wire logic irRxSelect,
  input wire logic irRxPadIn,
  output logic irRxPadOut,
  output logic irRxPadOe,
  output logic irReceiveIn,
  input wire logic irRxGioOut,
  input wire logic irRxGioOutEn,
  output logic irRxGioIn,
  input wire mups_tx_mode_t irTxMode,
  input wire logic irTransmitOut,
  input wire logic irTxGioOut,
  input wire logic irTxGioOutEn,
  output logic irTxPadOut,
  output logic irTxPadOe,
  // Push button and power
  input wire logic pushButtonIn,
  input wire logic pushButtonFlagClear,
  input wire logic lowPowerMode,
  output logic pushButtonFlag,
  output logic wakeUp,
  // Production test strap
  input wire logic productionTestIn,
  output logic productionTestActive
);

  // Picks the pad drive {out, oe}: alternate function or pixel drive
  function automatic logic [1:0] pickDrive(input logic useAlt, input logic [1:0] altDrv,
                                           input logic pixVal);
    return useAlt ? altDrv : {pixVal, PIXEL_OE};
  endfunction

  logic [GIO_N-1:0] next_gioOut, next_gioOe;
  logic [SPI_N-1:0] next_spiOut, next_spiOe;
  logic [EMU_N-1:0] next_emuOut, next_emuOe;
  logic [1:0] next_irTx;
  logic buttonRise;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lcdBackplaneOut <= '0;
      chipInReset <= RST_BIT;
    end else begin
      chipInReset <= chipResetIn;
      lcdBackplaneOut <= chipResetIn ? '0 : lcdBackplaneIn;
    end
  end

  always_comb begin
    for (int i = 0; i < GIO_N; i++) begin
      {next_gioOut[i], next_gioOe[i]} = pickDrive(gioSelect[i], {gioOut[i], gioOutEn[i]},
                                                  gioPixel[i]);
    end
    if (eepromEnable) begin
      {next_gioOut[GIO_EEP_CLK], next_gioOe[GIO_EEP_CLK]} = {eepClk, 1'h1};
      {next_gioOut[GIO_EEP_DATA], next_gioOe[GIO_EEP_DATA]} = {eepDataOut, eepDataOutEn};
    end
    if (pulseEnable) begin
      {next_gioOut[GIO_REAL_PULSE], next_gioOe[GIO_REAL_PULSE]} = {realEnergyPulse, 1'h1};
      {next_gioOut[GIO_REACT_PULSE], next_gioOe[GIO_REACT_PULSE]} =
        {reactiveEnergyPulse, 1'h1};
    end
  end

  always_comb begin
    for (int i = 0; i < SPI_N; i++) begin
      {next_spiOut[i], next_spiOe[i]} = pickDrive(spiSelect[i], 2'h0, spiPixel[i]);
    end
    if (spiSelect[SPI_DATA_OUT]) begin
      {next_spiOut[SPI_DATA_OUT], next_spiOe[SPI_DATA_OUT]} =
        {spiPortDataOut, spiPortDataOutEn};
    end
  end

  always_comb begin
    for (int i = 0; i < EMU_N; i++) begin
      {next_emuOut[i], next_emuOe[i]} = pickDrive(emulatorEnable, 2'h0, emuPixel[i]);
    end
    if (emulatorEnable) begin
      {next_emuOut[EMU_DATA], next_emuOe[EMU_DATA]} = {emulatorDataOut, emulatorDataOutEn};
      {next_emuOut[EMU_CLOCK], next_emuOe[EMU_CLOCK]} = {emulatorClock, 1'h1};
    end
  end

  always_comb begin
    case (irTxMode)
      MUPS_TX_GIO: next_irTx = {irTxGioOut, irTxGioOutEn};
      MUPS_TX_IR: next_irTx = {irTransmitOut, 1'h1};
      MUPS_TX_REAL: next_irTx = {realEnergyPulse, 1'h1};
      MUPS_TX_REACT: next_irTx = {reactiveEnergyPulse, 1'h1};
      default: next_irTx = {irTxGioOut, irTxGioOutEn};
    endcase
  end

  // pad registers held in reset by the chip reset pin
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gioPadOut <= '0;
      gioPadOe <= '0;
      spiPadOut <= '0;
      spiPadOe <= '0;
      emuPadOut <= '0;
      emuPadOe <= '0;
      irTxPadOut <= RST_BIT;
      irTxPadOe <= RST_BIT;
      irRxPadOut <= RST_BIT;
      irRxPadOe <= RST_BIT;
    end else if (chipResetIn) begin
      gioPadOut <= '0;
      gioPadOe <= '0;
      spiPadOut <= '0;
      spiPadOe <= '0;
      emuPadOut <= '0;
      emuPadOe <= '0;
      irTxPadOut <= RST_BIT;
      irTxPadOe <= RST_BIT;
      irRxPadOut <= RST_BIT;
      irRxPadOe <= RST_BIT;
    end else begin
      gioPadOut <= next_gioOut;
      gioPadOe <= next_gioOe;
      spiPadOut <= next_spiOut;
      spiPadOe <= next_spiOe;
      emuPadOut <= next_emuOut;
      emuPadOe <= next_emuOe;
      {irTxPadOut, irTxPadOe} <= next_irTx;
      // receive pad released while it listens to the detector
      irRxPadOut <= irRxSelect ? RST_BIT : irRxGioOut;
      irRxPadOe <= irRxSelect ? RST_BIT : irRxGioOutEn;
    end
  end

  // clock test and mux sync pads
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clockTestPad <= RST_BIT;
      muxSyncPad <= RST_BIT;
    end else begin
      clockTestPad <= clockTestOutEn ? clockTestSrc : clkTestPixel;
      muxSyncPad <= muxSyncOutEn ? muxSyncSrc : muxSyncPixel;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      testMuxOut <= RST_BIT;
    end else begin
      testMuxOut <= testMuxSources[testMuxSelect];
    end
  end

  // Inputs seen by the internal functions
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gioIn <= '0;
      eepDataIn <= RST_BIT;
      spiPortClk <= RST_BIT;
      spiPortSelectN <= RST_SELECT_N;
      spiPortDataIn <= RST_BIT;
      emulatorDataIn <= RST_BIT;
      emulatorResetIn <= RST_BIT;
      irReceiveIn <= RST_BIT;
      irRxGioIn <= RST_BIT;
    end else begin
      gioIn <= gioPadIn;
      eepDataIn <= eepromEnable & gioPadIn[GIO_EEP_DATA];
      spiPortClk <= spiSelect[SPI_CLK] & spiPadIn[SPI_CLK];
      spiPortSelectN <= ~spiSelect[SPI_SELECT_N] | spiPadIn[SPI_SELECT_N];
      spiPortDataIn <= spiSelect[SPI_DATA_IN] & spiPadIn[SPI_DATA_IN];
      emulatorDataIn <= emulatorEnable & emuPadIn[EMU_DATA];
      emulatorResetIn <= emulatorEnable & emuPadIn[EMU_RESET];
      irReceiveIn <= irRxSelect & irRxPadIn;
      irRxGioIn <= irRxPadIn;
    end
  end

  mups_button_edge u_button (
    .core_clk(core_clk),
    .nrst(nrst),
    .clearIn(chipResetIn),
    .buttonIn(pushButtonIn),
    .buttonRise(buttonRise)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pushButtonFlag <= RST_BIT;
    end else if (chipResetIn) begin
      pushButtonFlag <= RST_BIT;
    end else if (buttonRise) begin
      pushButtonFlag <= 1'h1;
    end else if (pushButtonFlagClear) begin
      pushButtonFlag <= RST_BIT;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wakeUp <= RST_BIT;
    end else begin
      wakeUp <= buttonRise & lowPowerMode & ~chipResetIn;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      productionTestActive <= RST_BIT;
    end else begin
      productionTestActive <= productionTestIn;
    end
  end

  property p_backplane;
    @(posedge core_clk) disable iff (!nrst)
    !chipResetIn |=> lcdBackplaneOut == $past(lcdBackplaneIn);
  endproperty
  a_backplane: assert property (p_backplane) else $error("backplane mismatch");

  property p_eeprom;
    @(posedge core_clk) disable iff (!nrst)
    eepromEnable && !chipResetIn |=>
      gioPadOut[GIO_EEP_CLK] == $past(eepClk) && gioPadOe[GIO_EEP_CLK];
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("eeprom clock not on line");

  property p_pulse;
    @(posedge core_clk) disable iff (!nrst)
    pulseEnable && !chipResetIn |=> gioPadOe[GIO_REACT_PULSE] &&
      gioPadOut[GIO_REAL_PULSE] == $past(realEnergyPulse) &&
      gioPadOut[GIO_REACT_PULSE] == $past(reactiveEnergyPulse);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse lines wrong");

  property p_spi;
    @(posedge core_clk) disable iff (!nrst)
    !spiSelect[SPI_CLK] && !chipResetIn |=>
      spiPadOe[SPI_CLK] && spiPadOut[SPI_CLK] == $past(spiPixel[SPI_CLK]) && !spiPortClk;
  endproperty
  a_spi: assert property (p_spi) else $error("serial clock pad not pixel drive");

  property p_emu;
    @(posedge core_clk) disable iff (!nrst)
    !emulatorEnable && !chipResetIn |=> emuPadOe == '1 && emuPadOut == $past(emuPixel);
  endproperty
  a_emu: assert property (p_emu) else $error("emulator pads not pixel drive");

  property p_clktest;
    @(posedge core_clk) disable iff (!nrst)
    clockTestOutEn |=> clockTestPad == $past(clockTestSrc);
  endproperty
  a_clktest: assert property (p_clktest) else $error("clock test pad wrong");

  property p_tmux;
    @(posedge core_clk) disable iff (!nrst)
    ##1 testMuxOut == $past(testMuxSources[testMuxSelect]);
  endproperty
  a_tmux: assert property (p_tmux) else $error("test mux wrong source");

  property p_irtx;
    @(posedge core_clk) disable iff (!nrst)
    irTxMode == MUPS_TX_REAL && !chipResetIn |=>
      irTxPadOe && irTxPadOut == $past(realEnergyPulse);
  endproperty
  a_irtx: assert property (p_irtx) else $error("optical tx not real pulse");

  property p_reset;
    @(posedge core_clk) disable iff (!nrst)
    chipResetIn |=> !pushButtonFlag && gioPadOe == '0 && !wakeUp;
  endproperty
  a_reset: assert property (p_reset) else $error("chip reset not honoured");

  property p_flag;
    @(posedge core_clk) disable iff (!nrst)
    $rose(pushButtonIn) && !chipResetIn ##1 (!chipResetIn) [*3] |=> pushButtonFlag;
  endproperty
  a_flag: assert property (p_flag) else $error("button edge did not set flag");

  property p_wake;
    @(posedge core_clk) disable iff (!nrst)
    buttonRise && lowPowerMode && !chipResetIn |=> wakeUp ##1 !wakeUp;
  endproperty
  a_wake: assert property (p_wake) else $error("wake pulse wrong");

  property p_once;
    @(posedge core_clk) disable iff (!nrst)
    buttonRise |=> !buttonRise;
  endproperty
  a_once: assert property (p_once) else $error("edge detected twice");

endmodule // mups_pin_mux

/* File: src/mups_pkg.sv */
package mups_pkg;

  // Pad group sizes, test mux size and select width, button synchronizer depth
  localparam int LCD_COM_N = 4;
  localparam int GIO_N = 4;
  localparam int SPI_N = 4;
  localparam int EMU_N = 3;
  localparam int TMUX_W = 4;
  localparam int TMUX_N = 16;
  localparam int SYNC_STAGES = 2;

  // General I/O pad index inside the shared group (lines 4 to 7)
  localparam int GIO_FIRST_LINE = 4;
  localparam int GIO_EEP_CLK = 0;
  localparam int GIO_EEP_DATA = 1;
  localparam int GIO_REAL_PULSE = 2;
  localparam int GIO_REACT_PULSE = 3;

  // Serial port pad index
  localparam int SPI_CLK = 0;
  localparam int SPI_DATA_OUT = 1;
  localparam int SPI_SELECT_N = 2;
  localparam int SPI_DATA_IN = 3;

  // Emulator pad index
  localparam int EMU_DATA = 0;
  localparam int EMU_RESET = 1;
  localparam int EMU_CLOCK = 2;

  // Reset values and pixel-drive output enable
  localparam logic RST_BIT = 1'h0;
  localparam logic RST_SELECT_N = 1'h1;
  localparam logic PIXEL_OE = 1'h1;

  // Optical transmit pad function, Gray coded
  typedef enum logic [1:0] {
    MUPS_TX_GIO = 2'h0,
    MUPS_TX_IR = 2'h1,
    MUPS_TX_REAL = 2'h3,
    MUPS_TX_REACT = 2'h2
  } mups_tx_mode_t;

endpackage

/* File: src/mups_button_edge.sv */
`timescale 1ns/1ps

module mups_button_edge
  import mups_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Control
  input wire logic clearIn,
  // Button
  input wire logic buttonIn,
  output logic buttonRise
);

  logic [SYNC_STAGES-1:0] syncChain;
  logic prevLevel;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      syncChain <= '0;
    end else begin
      syncChain <= {syncChain[SYNC_STAGES-2:0], buttonIn};
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prevLevel <= RST_BIT;
    end else begin
      prevLevel <= syncChain[SYNC_STAGES-1];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      buttonRise <= RST_BIT;
    end else if (clearIn) begin
      buttonRise <= RST_BIT;
    end else begin
      buttonRise <= syncChain[SYNC_STAGES-1] & ~prevLevel;
    end
  end

endmodule // mups_button_edge

/* File: verif/mups_pad_env.sv */
`timescale 1ns/1ps

module mups_pad_env #(
  parameter int N = 4
) (
  // Pad from the block
  input wire logic [N-1:0] padOut,
  input wire logic [N-1:0] padOe,
  // Far-side peripheral
  input wire logic [N-1:0] extLevel,
  input wire logic extDrive,
  // Level seen by the block
  output logic [N-1:0] padIn
);
  always_comb begin
    for (int i = 0; i < N; i++) begin
      padIn[i] = padOe[i] ? padOut[i] : (extDrive ? extLevel[i] : 1'b0);
    end
  end
endmodule // mups_pad_env

/* File: verif/tb_multi_use_pin_select.sv */
`timescale 1ns/1ps

module tb_multi_use_pin_select;
  import mups_pkg::*;
  logic core_clk, nrst, chipResetIn, clkTestPixel, muxSyncPixel, eepromEnable, eepClk;
  logic eepDataOut, eepDataOutEn, pulseEnable, realEnergyPulse, reactiveEnergyPulse;
  logic spiPortDataOut, spiPortDataOutEn, emulatorEnable, emulatorDataOut, emulatorDataOutEn;
  logic emulatorClock, clockTestOutEn, clockTestSrc, muxSyncOutEn, muxSyncSrc, irRxSelect;
  logic irRxPadIn, irRxGioOut, irRxGioOutEn, irTransmitOut, irTxGioOut, irTxGioOutEn;
  logic pushButtonIn, pushButtonFlagClear, lowPowerMode, productionTestIn;
  logic [3:0] lcdBackplaneIn, gioPixel, spiPixel, gioSelect, gioOut, gioOutEn, gioPadIn;
  logic [3:0] spiSelect, spiPadIn, testMuxSelect, lcdBackplaneOut, gioIn, gioPadOut, gioPadOe;
  logic [3:0] spiPadOut, spiPadOe;
  logic [2:0] emuPixel, emuPadIn, emuPadOut, emuPadOe;
  logic [15:0] testMuxSources;
  mups_tx_mode_t irTxMode;
  logic chipInReset, eepDataIn, spiPortClk, spiPortSelectN, spiPortDataIn, emulatorDataIn;
  logic emulatorResetIn, clockTestPad, muxSyncPad, testMuxOut, irRxPadOut, irRxPadOe;
  logic irReceiveIn, irRxGioIn, irTxPadOut, irTxPadOe, pushButtonFlag, wakeUp;
  logic productionTestActive;
  logic [11:0] extLvl;
  logic [2:0] extDrv;
  logic [31:0] rnd;
  logic [4:0] pbHist;
  logic flagExp;
  logic [97:0] q[$];
  int cyc, badCount, samplesChecked;
  wire [48:0] act = {gioPadOut, gioPadOe, spiPadOut, spiPadOe, emuPadOut, emuPadOe,
    clockTestPad, muxSyncPad, testMuxOut, irTxPadOut, irTxPadOe, irRxPadOe, lcdBackplaneOut,
    gioIn, irRxGioIn, chipInReset, productionTestActive, pushButtonFlag, wakeUp,
    eepDataIn, spiPortClk, spiPortSelectN, spiPortDataIn, emulatorDataIn, emulatorResetIn,
    irReceiveIn, irRxPadOut};

  mups_pin_mux uut (.*);
  mups_pad_env #(.N(4)) gioEnv (.padOut(gioPadOut), .padOe(gioPadOe), .extLevel(extLvl[3:0]),
    .extDrive(extDrv[0]), .padIn(gioPadIn));
  mups_pad_env #(.N(4)) spiEnv (.padOut(spiPadOut), .padOe(spiPadOe), .extLevel(extLvl[7:4]),
    .extDrive(extDrv[1]), .padIn(spiPadIn));
  mups_pad_env #(.N(3)) emuEnv (.padOut(emuPadOut), .padOe(emuPadOe),
    .extLevel(extLvl[10:8]), .extDrive(extDrv[2]), .padIn(emuPadIn));
  mups_pad_env #(.N(1)) irEnv (.padOut(irRxPadOut), .padOe(irRxPadOe), .extLevel(extLvl[11]),
    .extDrive(extDrv[0]), .padIn(irRxPadIn));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) begin
      s = s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    end
    return s;
  endfunction

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic drive();
    logic [31:0] r1, r2;
    rnd = lfsr(rnd);
    r1 = lfsr(rnd);
    r2 = lfsr(r1);
    rnd = r2;
    {lcdBackplaneIn, gioPixel, spiPixel, gioSelect, gioOut, gioOutEn, spiSelect,
      testMuxSelect} = rnd;
    testMuxSources = r1[15:0];
    {emuPixel, clkTestPixel, muxSyncPixel, eepromEnable, eepClk, eepDataOut, eepDataOutEn,
      pulseEnable, realEnergyPulse, reactiveEnergyPulse, spiPortDataOut, spiPortDataOutEn,
      emulatorEnable} = r1[30:16];
    {emulatorDataOut, emulatorDataOutEn, emulatorClock, clockTestOutEn, clockTestSrc,
      muxSyncOutEn, muxSyncSrc, irRxSelect, irRxGioOut, irRxGioOutEn, irTransmitOut, irTxGioOut,
      irTxGioOutEn} = r2[16:4];
    irTxMode = mups_tx_mode_t'(r2[3:2]);
    {lowPowerMode, pushButtonFlagClear} = r2[1:0];
    {extDrv, extLvl} = r2[31:17];
    if (cyc > 1500) emulatorEnable = 1'b0;
    chipResetIn = (cyc % 64) inside {60, 61, 62};
    pushButtonIn = (cyc % 16) inside {[4:7]} && (cyc % 64) < 52;
    productionTestIn = 1'b0;
  endtask

  task automatic calc();
    logic [3:0] go, ge, so, se, sm;
    logic [2:0] eo, ee, em;
    logic ck, ms, to, te, re, ro, rise, wk, mr;
    logic [7:0] inExp;
    pbHist = {pbHist[3:0], pushButtonIn};
    for (int i = 0; i < 4; i++) begin
      if (eepromEnable && i < 2) {go[i], ge[i]} = i ? {eepDataOut, eepDataOutEn} : {eepClk, 1'b1};
      else if (pulseEnable && i > 1) {go[i], ge[i]} = {i == 2 ? realEnergyPulse : reactiveEnergyPulse, 1'b1};
      else if (gioSelect[i]) {go[i], ge[i]} = {gioOut[i], gioOutEn[i]};
      else {go[i], ge[i]} = {gioPixel[i], PIXEL_OE};
      so[i] = spiSelect[i] ? spiPortDataOut : spiPixel[i];
      se[i] = spiSelect[i] ? (i == SPI_DATA_OUT && spiPortDataOutEn) : PIXEL_OE;
    end
    eo = emulatorEnable ? {emulatorClock, 1'b0, emulatorDataOut} : emuPixel;
    ee = emulatorEnable ? {2'h2, emulatorDataOutEn} : 3'h7;
    ck = clockTestOutEn ? clockTestSrc : clkTestPixel;
    ms = muxSyncOutEn ? muxSyncSrc : muxSyncPixel;
    case (irTxMode)
      MUPS_TX_GIO: {to, te} = {irTxGioOut, irTxGioOutEn};
      MUPS_TX_IR: {to, te} = {irTransmitOut, 1'b1};
      MUPS_TX_REAL: {to, te} = {realEnergyPulse, 1'b1};
      default: {to, te} = {reactiveEnergyPulse, 1'b1};
    endcase
    re = irRxSelect ? 1'b0 : irRxGioOutEn;
    ro = irRxSelect ? 1'b0 : irRxGioOut;
    inExp = {eepromEnable & gioPadIn[GIO_EEP_DATA], spiSelect[SPI_CLK] & spiPadIn[SPI_CLK],
      ~spiSelect[SPI_SELECT_N] | spiPadIn[SPI_SELECT_N],
      spiSelect[SPI_DATA_IN] & spiPadIn[SPI_DATA_IN], emulatorEnable & emuPadIn[EMU_DATA],
      emulatorEnable & emuPadIn[EMU_RESET], irRxSelect & irRxPadIn, 1'b0};
    sm = se | {4{chipResetIn}};
    em = ee | {3{chipResetIn}};
    mr = !chipResetIn;
    rise = pbHist[3] & ~pbHist[4];
    wk = rise & lowPowerMode & mr;
    flagExp = chipResetIn ? 1'b0 : (rise ? 1'b1 : (pushButtonFlagClear ? 1'b0 : flagExp));
    if (chipResetIn) {go, ge, so, se, eo, ee, to, te, re, ro} = '0;
    q.push_back({{go, ge, so, se, eo, ee, ck, ms, testMuxSources[testMuxSelect], to, te, re,
      mr ? lcdBackplaneIn : 4'h0, gioPadIn, irRxPadIn, chipResetIn, productionTestIn, flagExp,
      wk, inExp[7:1], ro}, {8'hff, sm, 4'hf, em, 3'h7, {3{mr}}, 3'h7, 4'hf, {5{mr}}, 4'hf,
      8'hff}});
  endtask

  always @(posedge core_clk) begin : watch
    logic [97:0] n;
    #0.5;
    if (q.size() > 0) begin
      n = q.pop_front();
      samplesChecked++;
      if ((act & n[48:0]) !== (n[97:49] & n[48:0])) begin
        badCount++;
        $display("ERROR t=%0t output mismatch exp %h got %h", $time, n[97:49], act);
      end
    end
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(2400 * 25);
    badCount++;
    $display("ERROR t=%0t run did not finish", $time);
    wrap_up();
  end

  initial begin
    {badCount, samplesChecked, cyc} = '0;
    {pbHist, flagExp} = '0;
    nrst = 1'b0;
    rnd = 32'h845b_1102;
    drive();
    repeat (3) @(posedge core_clk);
    #1 nrst = 1'b1;
    repeat (2000) begin
      @(posedge core_clk);
      #1;
      cyc++;
      drive();
      #1;
      calc();
    end
    @(posedge core_clk);
    #2;
    wrap_up();
  end
endmodule // tb_multi_use_pin_select
